// >>> rtl/mto_motion_threshold_offset_regs.sv
// Contract
// - high-g sample count is code plus one
// - high-g limit is 250 mg per step
// - x motion compared against 8-bit x limit
// - y motion compared against 8-bit y limit
// - wake limits fixed mg, 1g/256 steps
// - 12-bit gyro trims, 1/32 dps, added
// - x trim low byte at 0x4E
// - y trim high nibble at 0x4F bits 7:4
// - y trim low byte at 0x50
// - z trim low byte at 0x51
`timescale 1ns/1ps
`default_nettype none
module mto_motion_threshold_offset_regs #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire mto_pkg::mto_bus_s reg_bus_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // acceleration samples, magnitudes in mg
  input wire logic sample_valid_in,
  input wire logic [15:0] accel_x_mag_in,
  input wire logic [15:0] accel_y_mag_in,
  input wire logic [15:0] accel_z_mag_in,
  input wire logic [15:0] accel_norm_mg_in,
  // detector results
  output logic motion_wake_out,
  output logic high_accel_state_out,
  // gyro path
  input wire logic [DATA_W-1:0] gyro_x_raw_in,
  input wire logic [DATA_W-1:0] gyro_y_raw_in,
  input wire logic [DATA_W-1:0] gyro_z_raw_in,
  input wire logic [3:0] rate_z_trim_high_in,
  output logic [DATA_W-1:0] gyro_x_trim_out,
  output logic [DATA_W-1:0] gyro_y_trim_out,
  output logic [DATA_W-1:0] gyro_z_trim_out,
  // decoded configuration
  output logic [3:0] high_accel_sample_count_out,
  output logic [13:0] high_accel_limit_mg_out,
  output logic [7:0] motion_wake_x_limit_out,
  output logic [7:0] motion_wake_y_limit_out,
  output logic [7:0] motion_wake_z_limit_out
);
  // ==========================================================
  // functions
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a >= mto_pkg::MTO_ADDR_BASE) &&
             (a <= mto_pkg::MTO_ADDR_GYRO_Z_LOW);
  endfunction

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - mto_pkg::MTO_ADDR_BASE;
    reg_index = d[2:0];
  endfunction

  function automatic logic [15:0] wake_mg(input logic [7:0] code);
    logic [17:0] p;
    p = {10'h000, code} * mto_pkg::MTO_WAKE_FULL_MG;
    wake_mg = {6'h00, p[17:mto_pkg::MTO_WAKE_SHIFT]};
  endfunction

  function automatic logic [DATA_W-1:0] add_trim(
    input logic [DATA_W-1:0] raw,
    input logic [11:0] trim
  );
    add_trim = raw + {{(DATA_W-12){trim[11]}}, trim};
  endfunction

  // ==========================================================
  // register file
  logic [7:0] regs_reg [mto_pkg::MTO_REG_COUNT];
  logic [7:0] regs_next [mto_pkg::MTO_REG_COUNT];
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  always_comb begin
    regs_next = regs_reg;
    rvalid_next = reg_bus_in.rd;
    rdata_next = 8'h00;
    if (reg_bus_in.rd && mapped(reg_bus_in.addr)) begin
      rdata_next = regs_reg[reg_index(reg_bus_in.addr)];
    end
    if (reg_bus_in.wr && mapped(reg_bus_in.addr)) begin
      regs_next[reg_index(reg_bus_in.addr)] = reg_bus_in.data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < mto_pkg::MTO_REG_COUNT; i++) begin
        regs_reg[i] <= mto_pkg::MTO_RESET_VALUE;
      end
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

  // ==========================================================
  // configuration decode
  logic [2:0] count_code;
  logic [4:0] mag_code;
  logic [11:0] trim_x, trim_y, trim_z;
  logic [15:0] wake_x_mg, wake_y_mg, wake_z_mg;
  logic [3:0] cnt_reg, cnt_next;
  logic [13:0] lim_reg, lim_next;

  // decoded from the next image, so flops track the register
  assign count_code = regs_next[mto_pkg::MTO_IDX_HIGH_ACCEL]
    [mto_pkg::MTO_COUNT_MSB:mto_pkg::MTO_COUNT_LSB];
  assign mag_code = regs_next[mto_pkg::MTO_IDX_HIGH_ACCEL]
    [mto_pkg::MTO_MAG_MSB:mto_pkg::MTO_MAG_LSB];

  always_comb begin
    cnt_next = {1'b0, count_code} + 4'h1;
    lim_next = ({9'h000, mag_code} + 14'h0001) *
      mto_pkg::MTO_MAG_STEP_MG;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg <= 4'h1;
      lim_reg <= mto_pkg::MTO_MAG_STEP_MG;
    end else begin
      cnt_reg <= cnt_next;
      lim_reg <= lim_next;
    end
  end

  assign high_accel_sample_count_out = cnt_reg;
  assign high_accel_limit_mg_out = lim_reg;
  assign motion_wake_x_limit_out = regs_reg[mto_pkg::MTO_IDX_WAKE_X];
  assign motion_wake_y_limit_out = regs_reg[mto_pkg::MTO_IDX_WAKE_Y];
  assign motion_wake_z_limit_out = regs_reg[mto_pkg::MTO_IDX_WAKE_Z];
  assign wake_x_mg = wake_mg(motion_wake_x_limit_out);
  assign wake_y_mg = wake_mg(motion_wake_y_limit_out);
  assign wake_z_mg = wake_mg(motion_wake_z_limit_out);
  assign trim_x = {regs_reg[mto_pkg::MTO_IDX_GYRO_XY_HIGH]
    [mto_pkg::MTO_X_HIGH_MSB:mto_pkg::MTO_X_HIGH_LSB],
    regs_reg[mto_pkg::MTO_IDX_GYRO_X_LOW]};
  assign trim_y = {regs_reg[mto_pkg::MTO_IDX_GYRO_XY_HIGH]
    [mto_pkg::MTO_Y_HIGH_MSB:mto_pkg::MTO_Y_HIGH_LSB],
    regs_reg[mto_pkg::MTO_IDX_GYRO_Y_LOW]};
  assign trim_z = {rate_z_trim_high_in,
    regs_reg[mto_pkg::MTO_IDX_GYRO_Z_LOW]};

  // ==========================================================
  // detectors and gyro trim
  mto_pkg::mto_state_e state_reg, state_next;
  logic [3:0] run_reg, run_next;
  logic wake_reg, wake_next;
  logic [DATA_W-1:0] gx_reg, gx_next, gy_reg, gy_next, gz_reg, gz_next;

  always_comb begin
    state_next = state_reg;
    run_next = run_reg;
    wake_next = 1'b0;
    gx_next = add_trim(gyro_x_raw_in, trim_x);
    gy_next = add_trim(gyro_y_raw_in, trim_y);
    gz_next = add_trim(gyro_z_raw_in, trim_z);
    if (sample_valid_in) begin
      wake_next = (accel_x_mag_in > wake_x_mg) ||
                  (accel_y_mag_in > wake_y_mg) ||
                  (accel_z_mag_in > wake_z_mg);
      if ({2'b00, accel_norm_mg_in[13:0]} != accel_norm_mg_in ||
          accel_norm_mg_in[13:0] > high_accel_limit_mg_out) begin
        if (run_reg != 4'hF) begin
          run_next = run_reg + 4'h1;
        end
        case (state_reg)
          mto_pkg::MTO_QUIET: begin
            if (run_reg + 4'h1 >= high_accel_sample_count_out) begin
              state_next = mto_pkg::MTO_HIGH;
            end
          end
          mto_pkg::MTO_HIGH: state_next = mto_pkg::MTO_HIGH;
          default: state_next = mto_pkg::MTO_QUIET;
        endcase
      end else begin
        run_next = 4'h0;
        state_next = mto_pkg::MTO_QUIET;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= mto_pkg::MTO_QUIET;
      run_reg <= 4'h0;
      wake_reg <= 1'b0;
      gx_reg <= '0;
      gy_reg <= '0;
      gz_reg <= '0;
    end else begin
      state_reg <= state_next;
      run_reg <= run_next;
      wake_reg <= wake_next;
      gx_reg <= gx_next;
      gy_reg <= gy_next;
      gz_reg <= gz_next;
    end
  end

  assign motion_wake_out = wake_reg;
  assign high_accel_state_out = (state_reg == mto_pkg::MTO_HIGH);
  assign gyro_x_trim_out = gx_reg;
  assign gyro_y_trim_out = gy_reg;
  assign gyro_z_trim_out = gz_reg;

  // ==========================================================
  // assertions
  a_count_decode: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_bus_in.wr && reg_bus_in.addr == mto_pkg::MTO_ADDR_HIGH_ACCEL |=>
    high_accel_sample_count_out == {1'b0, $past(reg_bus_in.data[2:0])} + 4'h1)
    else $error("sample count decode wrong");
  a_mag_decode: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_bus_in.wr && reg_bus_in.addr == mto_pkg::MTO_ADDR_HIGH_ACCEL &&
    reg_bus_in.data[7:3] == 5'h16 |=> high_accel_limit_mg_out == 14'h1676)
    else $error("high-g limit decode wrong");
  a_x_limit: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_bus_in.wr && reg_bus_in.addr == mto_pkg::MTO_ADDR_WAKE_X |=>
    motion_wake_x_limit_out == $past(reg_bus_in.data))
    else $error("x wake limit not stored");
  a_y_limit: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_bus_in.wr && reg_bus_in.addr == mto_pkg::MTO_ADDR_WAKE_Y |=>
    motion_wake_y_limit_out == $past(reg_bus_in.data))
    else $error("y wake limit not stored");
  a_z_limit: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_bus_in.wr && reg_bus_in.addr == mto_pkg::MTO_ADDR_WAKE_Z |=>
    motion_wake_z_limit_out == $past(reg_bus_in.data))
    else $error("z wake limit not stored");
  a_wake_scale: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sample_valid_in && accel_x_mag_in > 16'h03E8 |=> motion_wake_out)
    else $error("above 1 g must wake");
  a_wake_quiet: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !sample_valid_in |=> !motion_wake_out)
    else $error("wake without a sample");
  a_gyro_x_sum: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_bus_in.wr && reg_bus_in.addr == mto_pkg::MTO_ADDR_GYRO_X_LOW ##1
    !reg_bus_in.wr |=> gyro_x_trim_out - $past(gyro_x_raw_in) ==
    {{(DATA_W-12){$past(regs_reg[5][3], 2)}},
     $past(regs_reg[5][3:0], 2), $past(reg_bus_in.data, 2)})
    else $error("x trim not added");
  a_read_back: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_bus_in.rd && reg_bus_in.addr == mto_pkg::MTO_ADDR_GYRO_XY_HIGH |=>
    reg_rvalid_out && reg_rdata_out == $past(regs_reg[5]))
    else $error("read data wrong");
  a_high_drop: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sample_valid_in && accel_norm_mg_in <= {2'b00, high_accel_limit_mg_out}
    |=> !high_accel_state_out)
    else $error("high-g held below limit");
endmodule
`default_nettype wire

// >>> rtl/mto_pkg.sv
`default_nettype none
package mto_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] MTO_ADDR_BASE = 8'h4A;
  localparam logic [7:0] MTO_ADDR_HIGH_ACCEL = 8'h4A;
  localparam logic [7:0] MTO_ADDR_WAKE_X = 8'h4B;
  localparam logic [7:0] MTO_ADDR_WAKE_Y = 8'h4C;
  localparam logic [7:0] MTO_ADDR_WAKE_Z = 8'h4D;
  localparam logic [7:0] MTO_ADDR_GYRO_X_LOW = 8'h4E;
  localparam logic [7:0] MTO_ADDR_GYRO_XY_HIGH = 8'h4F;
  localparam logic [7:0] MTO_ADDR_GYRO_Y_LOW = 8'h50;
  localparam logic [7:0] MTO_ADDR_GYRO_Z_LOW = 8'h51;
  localparam int MTO_REG_COUNT = 8;
  localparam logic [2:0] MTO_IDX_HIGH_ACCEL = 3'h0;
  localparam logic [2:0] MTO_IDX_WAKE_X = 3'h1;
  localparam logic [2:0] MTO_IDX_WAKE_Y = 3'h2;
  localparam logic [2:0] MTO_IDX_WAKE_Z = 3'h3;
  localparam logic [2:0] MTO_IDX_GYRO_X_LOW = 3'h4;
  localparam logic [2:0] MTO_IDX_GYRO_XY_HIGH = 3'h5;
  localparam logic [2:0] MTO_IDX_GYRO_Y_LOW = 3'h6;
  localparam logic [2:0] MTO_IDX_GYRO_Z_LOW = 3'h7;
  localparam logic [7:0] MTO_RESET_VALUE = 8'h00;
  // ==========================================================
  // field positions
  localparam int MTO_COUNT_LSB = 0;
  localparam int MTO_COUNT_MSB = 2;
  localparam int MTO_MAG_LSB = 3;
  localparam int MTO_MAG_MSB = 7;
  localparam int MTO_X_HIGH_LSB = 0;
  localparam int MTO_X_HIGH_MSB = 3;
  localparam int MTO_Y_HIGH_LSB = 4;
  localparam int MTO_Y_HIGH_MSB = 7;
  // ==========================================================
  // scaling
  localparam logic [13:0] MTO_MAG_STEP_MG = 14'h00FA;
  localparam logic [17:0] MTO_WAKE_FULL_MG = 18'h003E8;
  localparam int MTO_WAKE_SHIFT = 8;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } mto_bus_s;
  typedef enum logic [0:0] {
    MTO_QUIET = 1'b0,
    MTO_HIGH = 1'b1
  } mto_state_e;
endpackage
`default_nettype wire

// >>> tb/mto_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// host on the register port
module mto_host (
  // clock
  input wire logic sys_clk_in,
  // register port
  output var mto_pkg::mto_bus_s bus_out,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in
);
  initial bus_out = '0;
  // one access; released lines then show inverted values
  task automatic put(input logic w, input logic [7:0] a, d);
    @(posedge sys_clk_in);
    bus_out <= {w, ~w, a, d};
    @(posedge sys_clk_in);
    bus_out <= {2'b00, ~a, ~d};
  endtask
  task automatic wr(input logic [7:0] a, d);
    put(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 'x;
    put(1'b0, a, 8'h00);
    repeat (3) begin
      @(posedge sys_clk_in);
      if (rvalid_in === 1'b1) begin
        d = rdata_in;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  mto_pkg::mto_bus_s bus;
  logic [7:0] rdata;
  logic rvalid;
  logic sample_valid = 1'b0;
  logic [15:0] m [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [3:0] z_high = 4'h9;
  logic [15:0] g_raw = 16'h1000;
  logic wake, high;
  logic [15:0] gx, gy, gz;
  logic [3:0] cnt;
  logic [13:0] lim;
  logic [7:0] lx, ly, lz, rd_val;
  logic [7:0] vals [8] = '{8'h00, 8'h40, 8'h80, 8'hFF,
                           8'h34, 8'hA5, 8'h67, 8'h89};
  logic [15:0] wlim [3] = '{16'h00FA, 16'h01F4, 16'h03E4};
  logic [15:0] norms [7] = '{16'h01F5, 16'h01F5, 16'h01F4, 16'h01F5,
                             16'h01F5, 16'h01F5, 16'h01F4};
  logic hexp [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  int errors = 0;
  int cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  mto_motion_threshold_offset_regs #(.DATA_W(16))
    u_mto_motion_threshold_offset_regs (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .reg_bus_in(bus),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .sample_valid_in(sample_valid), .accel_x_mag_in(m[0]),
    .accel_y_mag_in(m[1]), .accel_z_mag_in(m[2]),
    .accel_norm_mg_in(m[3]), .motion_wake_out(wake),
    .high_accel_state_out(high), .gyro_x_raw_in(g_raw),
    .gyro_y_raw_in(g_raw), .gyro_z_raw_in(g_raw),
    .rate_z_trim_high_in(z_high), .gyro_x_trim_out(gx),
    .gyro_y_trim_out(gy), .gyro_z_trim_out(gz),
    .high_accel_sample_count_out(cnt), .high_accel_limit_mg_out(lim),
    .motion_wake_x_limit_out(lx), .motion_wake_y_limit_out(ly),
    .motion_wake_z_limit_out(lz));
  mto_host u_mto_host (.sys_clk_in(sys_clk), .bus_out(bus),
    .rdata_in(rdata), .rvalid_in(rvalid));
  // ==================================================
  // tasks
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] a, e);
    u_mto_host.rd(a, rd_val);
    `CHK(rd_val, e)
  endtask
  task automatic samp(input logic [15:0] x, y, z, n);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    m <= '{x, y, z, n};
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    #1;
  endtask
  // ==================================================
  // tests
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    `CHK(cnt, 4'h1)
    `CHK(lim, 14'h00FA)
    for (int i = 0; i < 9; i++) chk_rd(8'(8'h4A + i), 8'h00);
    for (int i = 0; i < 8; i++) u_mto_host.wr(8'(8'h4A + i), vals[i]);
    u_mto_host.wr(8'h49, 8'hFF);
    u_mto_host.wr(8'h52, 8'hFF);
    for (int i = 0; i < 8; i++) chk_rd(8'(8'h4A + i), vals[i]);
    chk_rd(8'h49, 8'h00);
    chk_rd(8'h52, 8'h00);
    `CHK(lx, 8'h40)
    `CHK(ly, 8'h80)
    `CHK(lz, 8'hFF)
    `CHK(gx, 16'h1534)
    `CHK(gy, 16'h0A67)
    `CHK(gz, 16'h0989)
    // wake limits: at limit quiet, one mg above wakes
    for (int k = 0; k < 3; k++) begin
      for (int o = 0; o < 2; o++) begin
        case (k)
          0: samp(wlim[0] + 16'(o), 16'h0000, 16'h0000, 16'h0000);
          1: samp(16'h0000, wlim[1] + 16'(o), 16'h0000, 16'h0000);
          default: samp(16'h0000, 16'h0000, wlim[2] + 16'(o), 16'h0000);
        endcase
        `CHK(wake, 1'(o))
      end
    end
    // full-scale code stays below 1 g
    u_mto_host.wr(8'h4B, 8'hFF);
    samp(16'h03E4, 16'h0000, 16'h0000, 16'h0000);
    `CHK(wake, 1'b0)
    samp(16'h03E9, 16'h0000, 16'h0000, 16'h0000);
    `CHK(wake, 1'b1)
    // every high-g code
    for (int c = 0; c < 32; c++) begin
      u_mto_host.wr(8'h4A, 8'(c * 8 + c % 8));
      #1;
      `CHK(cnt, 4'(c % 8 + 1))
      `CHK(lim, 14'((c + 1) * 250))
    end
    // 500 mg, three samples, run broken by an at-limit sample
    u_mto_host.wr(8'h4A, 8'h0A);
    for (int i = 0; i < 7; i++) begin
      samp(16'h0000, 16'h0000, 16'h0000, norms[i]);
      `CHK(high, hexp[i])
    end
    // reset in mid-run brings count, limit, x wake limit, x trim and 0x4F back
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(cnt, 4'h1)
    `CHK(lim, 14'h00FA)
    `CHK(lx, 8'h00)
    `CHK(gx, 16'h0000)
    @(posedge sys_clk);
    reset_n <= 1'b1;
    chk_rd(8'h4F, 8'h00);
    `CHK(gx, 16'h1000)
    finish_test();
  end
endmodule
`default_nettype wire
